// ### design/drs_pkg.sv
`default_nettype none
package drs_pkg;
    // Register offsets
    localparam logic [7:0] DRS_OFS_REF_STEP_ONE = 8'h05;
    localparam logic [7:0] DRS_OFS_DIV_STEP_ONE = 8'h07;
    localparam logic [7:0] DRS_OFS_REF_STEP_TWO = 8'h19;
    localparam logic [7:0] DRS_OFS_DIV_STEP_TWO = 8'h1b;
    localparam logic [7:0] DRS_OFS_REF_FIRE = 8'h1d;
    localparam logic [7:0] DRS_OFS_DIV_FIRE = 8'h1f;
    localparam int DRS_NUM_REGS = 6;
    // Request bit position and writable low-field masks (reserved bits read zero)
    localparam int DRS_REQ_BIT = 7;
    localparam logic [6:0] DRS_MASK_REF_STEP_ONE = 7'h7f;
    localparam logic [6:0] DRS_MASK_DIV_STEP_ONE = 7'h2f;
    localparam logic [6:0] DRS_MASK_REF_STEP_TWO = 7'h3f;
    localparam logic [6:0] DRS_MASK_DIV_STEP_TWO = 7'h70;
    localparam logic [6:0] DRS_MASK_REF_FIRE = 7'h00;
    localparam logic [6:0] DRS_MASK_DIV_FIRE = 7'h00;
    localparam logic [6:0] DRS_LOW_RESET = 7'h00;
    // Timing: restart must land within this many clock periods of the fire write
    localparam int DRS_CLK_PERIOD_NS = 100;
    localparam int DRS_RESTART_MAX_NS = 1000;
    localparam int DRS_RESTART_MAX_CYC = DRS_RESTART_MAX_NS / DRS_CLK_PERIOD_NS;
    localparam int DRS_RESTART_CYC = 4;
    localparam logic [3:0] DRS_RESTART_CNT = 4'(DRS_RESTART_CYC);
    // Counts and widths
    localparam int DRS_NUM_CLK_OUT = 3;
    localparam int DRS_NUM_REF_OUT = 4;
    localparam int DRS_RATIO_W = 7;
    localparam logic [6:0] DRS_REF_RATIO_DEFAULT = 7'h08;
    typedef enum logic [1:0] {DRS_DIV_IDLE, DRS_DIV_ONE, DRS_DIV_TWO, DRS_DIV_FIRE} drs_div_state_type;
    typedef enum logic [1:0] {DRS_REF_IDLE, DRS_REF_ONE, DRS_REF_TWO, DRS_REF_PULSE} drs_ref_state_type;
endpackage
`default_nettype wire

// ### design/drs_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// Output divider with synchronous hold; restarts high on the first cycle after hold drops
module drs_clkdiv #(
    parameter int RATIO_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic [RATIO_W-1:0] ratio_i,
    output logic q_o
);
    logic [RATIO_W-1:0] cnt_reg;
    logic [RATIO_W-1:0] ratio_eff;
    logic [RATIO_W-1:0] half;

    // Ratios below two cannot be made from the system clock, so clamp
    assign ratio_eff = (ratio_i < RATIO_W'(2)) ? RATIO_W'(2) : ratio_i;
    // Rounded-up half without an add that could wrap at the top ratio
    assign half = (ratio_eff >> 1) + RATIO_W'(ratio_eff[0]);

    // Counter and output both clear under hold so every divider starts in phase
    always_ff @(posedge clk_i) begin
        if (rst_i || hold_i) begin
            cnt_reg <= '0;
            q_o <= 1'b0;
        end else begin
            q_o <= (cnt_reg < half);
            cnt_reg <= (cnt_reg >= ratio_eff - RATIO_W'(1)) ? '0 : cnt_reg + RATIO_W'(1);
        end
    end
endmodule
`default_nettype wire

// ### design/drs_resync_ctrl.sv
// Operation
// [R1] First divider request forces all clock outputs low and starts the resync.
// [R2] All six request bits self-clear when done; writing zero changes nothing.
// [R3] Divider fire acts only after the second divider request is set.
// [R4] After fire, all clock outputs restart together with a rising edge.
// [R5] Divider fire is the final step; dividers restart within ten clock periods.
// [R6] Second divider request and fire clear only after outputs have been reset.
// [R7] Software runs divider resync after power-up and each divider change.
// [R8] Reference steps go one, two, fire in order, then pulses emit.
// [R9] Reference sequence bits work only while override mode is zero.
// [R10] Second reference request resets reference divider and holds outputs low.
// [R11] Fire emits exactly the programmed eight-bit count on enabled outputs.
// [R12] Reference fire clears itself once all programmed pulses are out.
// [R13] Software runs reference sync after every reference delay reconfiguration.
// [R14] Second reference request clears only after the reference outputs reset.
// [R15] Request bits read one until completion; out-of-order fire writes ignored.
`timescale 1ns/1ps
`default_nettype none
module drs_resync_ctrl #(
    parameter logic [6:0] REF_RATIO = drs_pkg::DRS_REF_RATIO_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [drs_pkg::DRS_RATIO_W-1:0] div_ratio_i [drs_pkg::DRS_NUM_CLK_OUT],
    input wire logic [7:0] refpulse_count_i,
    input wire logic refpulse_override_mode_i,
    input wire logic [drs_pkg::DRS_NUM_REF_OUT-1:0] ref_enable_i,
    output logic [drs_pkg::DRS_NUM_CLK_OUT-1:0] clock_outputs_o,
    output logic [drs_pkg::DRS_NUM_REF_OUT-1:0] reference_pulse_outputs_o
);
    import drs_pkg::*;

    drs_div_state_type div_state_reg;
    drs_ref_state_type ref_state_reg;
    logic [6:0] low_reg [DRS_NUM_REGS];
    logic [3:0] fire_cnt_reg;
    logic [7:0] pulse_cnt_reg;
    logic ref_q;
    logic ref_q_prev_reg;
    logic ref_fall;
    logic div_hold;
    logic ref_hold;
    logic [7:0] read_value;

    // Map an offset to its slot, or DRS_NUM_REGS when unmapped
    function automatic int slot_of(input logic [7:0] addr);
        case (addr)
            DRS_OFS_REF_STEP_ONE: slot_of = 0;
            DRS_OFS_DIV_STEP_ONE: slot_of = 1;
            DRS_OFS_REF_STEP_TWO: slot_of = 2;
            DRS_OFS_DIV_STEP_TWO: slot_of = 3;
            DRS_OFS_REF_FIRE: slot_of = 4;
            DRS_OFS_DIV_FIRE: slot_of = 5;
            default: slot_of = DRS_NUM_REGS;
        endcase
    endfunction

    function automatic logic [6:0] mask_of(input int slot);
        case (slot)
            0: mask_of = DRS_MASK_REF_STEP_ONE;
            1: mask_of = DRS_MASK_DIV_STEP_ONE;
            2: mask_of = DRS_MASK_REF_STEP_TWO;
            3: mask_of = DRS_MASK_DIV_STEP_TWO;
            4: mask_of = DRS_MASK_REF_FIRE;
            5: mask_of = DRS_MASK_DIV_FIRE;
            default: mask_of = 7'h00;
        endcase
    endfunction

    // A one in the request position of a write to the given offset
    function automatic logic req_write(input logic wr, input logic [7:0] addr,
                                       input logic [7:0] data, input logic [7:0] ofs);
        req_write = wr && (addr == ofs) && data[DRS_REQ_BIT];
    endfunction

    logic wr_div_one, wr_div_two, wr_div_fire, wr_ref_one, wr_ref_two, wr_ref_fire;
    assign wr_div_one = req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_DIV_STEP_ONE);
    assign wr_div_two = req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_DIV_STEP_TWO);
    assign wr_div_fire = req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_DIV_FIRE);
    // Reference bits are dead while override mode is set
    assign wr_ref_one = !refpulse_override_mode_i &&
        req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_REF_STEP_ONE); // [R9]
    assign wr_ref_two = !refpulse_override_mode_i &&
        req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_REF_STEP_TWO); // [R9]
    assign wr_ref_fire = !refpulse_override_mode_i &&
        req_write(reg_wr_i, reg_addr_i, reg_wdata_i, DRS_OFS_REF_FIRE); // [R9]

    // Plain storage for the fields sharing these registers; the block does not interpret them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DRS_NUM_REGS; i++) begin
                low_reg[i] <= DRS_LOW_RESET;
            end
        end else if (reg_wr_i && slot_of(reg_addr_i) < DRS_NUM_REGS) begin
            low_reg[slot_of(reg_addr_i)] <= reg_wdata_i[6:0] & mask_of(slot_of(reg_addr_i));
        end
    end

    // Divider resync sequence; a zero write or an out-of-order step leaves state alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_state_reg <= DRS_DIV_IDLE;
            fire_cnt_reg <= '0;
        end else begin
            case (div_state_reg)
                DRS_DIV_IDLE: begin
                    if (wr_div_one) begin
                        div_state_reg <= DRS_DIV_ONE; // [R1]
                    end
                end
                DRS_DIV_ONE: begin
                    if (wr_div_two) begin
                        div_state_reg <= DRS_DIV_TWO; // [R3]
                    end
                end
                DRS_DIV_TWO: begin
                    if (wr_div_fire) begin
                        div_state_reg <= DRS_DIV_FIRE; // [R3] [R15]
                        fire_cnt_reg <= '0;
                    end
                end
                DRS_DIV_FIRE: begin
                    // Release happens with completion, so bits clear one cycle before outputs restart
                    if (fire_cnt_reg == DRS_RESTART_CNT - 4'h1) begin
                        div_state_reg <= DRS_DIV_IDLE; // [R5] [R6] [R2]
                    end else begin
                        fire_cnt_reg <= fire_cnt_reg + 4'h1;
                    end
                end
                default: div_state_reg <= DRS_DIV_IDLE;
            endcase
        end
    end

    // All dividers held low from the first step until the fire delay expires
    assign div_hold = (div_state_reg != DRS_DIV_IDLE); // [R1]

    // Shared hold gives every output the same restart edge regardless of ratio
    genvar g;
    generate
        for (g = 0; g < DRS_NUM_CLK_OUT; g++) begin : gen_div
            drs_clkdiv #(.RATIO_W(DRS_RATIO_W)) u_div (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .hold_i(div_hold), // [R4]
                .ratio_i(div_ratio_i[g]),
                .q_o(clock_outputs_o[g])
            );
        end
    endgenerate

    // Reference divider runs only while a burst is being sent
    assign ref_hold = (ref_state_reg != DRS_REF_PULSE); // [R10]

    drs_clkdiv #(.RATIO_W(DRS_RATIO_W)) u_refdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(ref_hold),
        .ratio_i(REF_RATIO),
        .q_o(ref_q)
    );

    assign ref_fall = ref_q_prev_reg && !ref_q;

    // Reference sync sequence and burst counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_state_reg <= DRS_REF_IDLE;
            pulse_cnt_reg <= '0;
            ref_q_prev_reg <= 1'b0;
        end else begin
            ref_q_prev_reg <= ref_q;
            case (ref_state_reg)
                DRS_REF_IDLE: begin
                    if (wr_ref_one) begin
                        ref_state_reg <= DRS_REF_ONE; // [R8]
                    end
                end
                DRS_REF_ONE: begin
                    if (wr_ref_two) begin
                        ref_state_reg <= DRS_REF_TWO; // [R8] [R10]
                    end
                end
                DRS_REF_TWO: begin
                    if (wr_ref_fire && refpulse_count_i == 8'h00) begin
                        ref_state_reg <= DRS_REF_IDLE; // [R12] [R14]
                    end else if (wr_ref_fire) begin
                        ref_state_reg <= DRS_REF_PULSE; // [R8] [R15]
                        pulse_cnt_reg <= '0;
                    end
                end
                DRS_REF_PULSE: begin
                    // A pulse counts on its falling edge, so the last one is whole
                    if (ref_fall && pulse_cnt_reg + 8'h01 >= refpulse_count_i) begin
                        ref_state_reg <= DRS_REF_IDLE; // [R11] [R12] [R14]
                        pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
                    end else if (ref_fall) begin
                        pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
                    end
                end
                default: ref_state_reg <= DRS_REF_IDLE;
            endcase
        end
    end

    // Enabled outputs follow the burst; low during step two and idle
    always_comb begin
        reference_pulse_outputs_o = '0; // [R10]
        if (ref_state_reg == DRS_REF_PULSE) begin
            reference_pulse_outputs_o = {DRS_NUM_REF_OUT{ref_q}} & ref_enable_i; // [R11]
        end
    end

    // Request bits show sequence progress in the top bit
    always_comb begin
        read_value = 8'h00;
        case (reg_addr_i)
            DRS_OFS_REF_STEP_ONE: read_value = {ref_state_reg != DRS_REF_IDLE, low_reg[0]}; // [R15]
            DRS_OFS_DIV_STEP_ONE: read_value = {div_state_reg != DRS_DIV_IDLE, low_reg[1]};
            DRS_OFS_REF_STEP_TWO: read_value = {(ref_state_reg == DRS_REF_TWO) ||
                                                (ref_state_reg == DRS_REF_PULSE), low_reg[2]};
            DRS_OFS_DIV_STEP_TWO: read_value = {(div_state_reg == DRS_DIV_TWO) ||
                                                (div_state_reg == DRS_DIV_FIRE), low_reg[3]};
            DRS_OFS_REF_FIRE: read_value = {ref_state_reg == DRS_REF_PULSE, low_reg[4]};
            DRS_OFS_DIV_FIRE: read_value = {div_state_reg == DRS_DIV_FIRE, low_reg[5]};
            default: read_value = 8'h00;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= read_value;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_div_low;
        (div_state_reg == DRS_DIV_ONE && $past(div_hold)) |-> clock_outputs_o == '0;
    endproperty
    a_div_low: assert property (p_div_low) else $error("clock outputs not low in step one"); // [R1]

    property p_div_start;
        (div_state_reg == DRS_DIV_IDLE && wr_div_one) |=> ##1 clock_outputs_o == '0;
    endproperty
    a_div_start: assert property (p_div_start) else $error("step one did not hold outputs"); // [R1]

    property p_zero_write;
        (div_state_reg == DRS_DIV_IDLE && reg_wr_i && reg_addr_i == DRS_OFS_DIV_STEP_ONE &&
         !reg_wdata_i[DRS_REQ_BIT]) |=> div_state_reg == DRS_DIV_IDLE;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write started sequence"); // [R2]

    property p_fire_early;
        (div_state_reg == DRS_DIV_ONE && wr_div_fire && !wr_div_two) |=>
            div_state_reg == DRS_DIV_ONE;
    endproperty
    a_fire_early: assert property (p_fire_early) else $error("fire accepted before step two"); // [R3]

    property p_restart_all;
        $fell(div_hold) |=> clock_outputs_o == '1;
    endproperty
    a_restart_all: assert property (p_restart_all) else $error("outputs did not rise together"); // [R4]

    property p_restart_time;
        (div_state_reg == DRS_DIV_TWO && wr_div_fire) |-> ##[1:10] clock_outputs_o == '1;
    endproperty
    a_restart_time: assert property (p_restart_time) else $error("restart later than ten cycles"); // [R5]

    property p_two_held;
        div_state_reg == DRS_DIV_FIRE |-> div_hold && clock_outputs_o == '0;
    endproperty
    a_two_held: assert property (p_two_held) else $error("outputs moved before completion"); // [R6]

    property p_override;
        (refpulse_override_mode_i && ref_state_reg == DRS_REF_IDLE) |=>
            ref_state_reg == DRS_REF_IDLE;
    endproperty
    a_override: assert property (p_override) else $error("reference step ran in override"); // [R9]

    property p_ref_low;
        ref_state_reg == DRS_REF_TWO |-> reference_pulse_outputs_o == '0 && ref_hold;
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("reference outputs not held low"); // [R10]

    property p_ref_count;
        (ref_state_reg == DRS_REF_PULSE ##1 ref_state_reg == DRS_REF_IDLE) |->
            pulse_cnt_reg == refpulse_count_i;
    endproperty
    a_ref_count: assert property (p_ref_count) else $error("pulse count differs"); // [R11] [R12]

    c_div_done: cover property (div_state_reg == DRS_DIV_FIRE ##1 div_state_reg == DRS_DIV_IDLE);
    c_ref_burst: cover property (ref_state_reg == DRS_REF_PULSE ##1 ref_state_reg == DRS_REF_IDLE);
    c_override: cover property (refpulse_override_mode_i && wr_ref_fire == 1'b0 &&
                                reg_wr_i && reg_addr_i == DRS_OFS_REF_STEP_ONE);
endmodule
`default_nettype wire

// ### tb/drs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host software stand-in: drives the parallel strobe port that replaces the serial link
module drs_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o
);
    // Idle bus at time zero so the design never samples unknown strobes
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        data_o = 8'h00;
    end

    // One-cycle write; address and data held through the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask

    // Read data is registered at the taking edge, so look just after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask

    // Steps always issued one, two, fire; callers rerun after divider or delay changes
    task automatic run_seq(input logic [7:0] a1, input logic [7:0] a2, input logic [7:0] a3);
        wr(a1, 8'h80);
        wr(a2, 8'h80);
        wr(a3, 8'h80);
    endtask
endmodule
`default_nettype wire

// ### tb/drs_resync_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module drs_resync_ctrl_bench;
    import drs_pkg::*;
    logic clk_i;
    logic rst_i;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [6:0] ratio [3];
    logic [7:0] pulse_cnt;
    logic override_mode;
    logic [3:0] ref_en;
    logic [2:0] clk_out;
    logic [3:0] ref_out;
    int num_errors;
    int n_checks;
    logic [7:0] v;

    drs_resync_ctrl uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata),
        .div_ratio_i(ratio),
        .refpulse_count_i(pulse_cnt),
        .refpulse_override_mode_i(override_mode),
        .ref_enable_i(ref_en),
        .clock_outputs_o(clk_out),
        .reference_pulse_outputs_o(ref_out)
    );

    drs_host_model host (
        .clk_i(clk_i),
        .rdata_i(reg_rdata),
        .wr_o(reg_wr),
        .rd_o(reg_rd),
        .addr_o(reg_addr),
        .data_o(reg_wdata)
    );

    // 100 ns period
    always #50 clk_i = ~clk_i;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Full divider resync with the outputs watched at every step
    task automatic div_run;
        int k;
        host.wr(DRS_OFS_DIV_STEP_ONE, 8'hff);
        repeat (2) @(posedge clk_i);
        #1;
        chk("clk_low_step_one", 8'h00, {5'h00, clk_out});
        host.rd(DRS_OFS_DIV_STEP_ONE, v);
        chk("div_one_busy", 8'haf, v);
        // A fire ahead of step two must be dropped
        host.wr(DRS_OFS_DIV_FIRE, 8'h80);
        host.rd(DRS_OFS_DIV_FIRE, v);
        chk("div_fire_early", 8'h00, v);
        host.wr(DRS_OFS_DIV_STEP_TWO, 8'h80);
        host.rd(DRS_OFS_DIV_STEP_TWO, v);
        chk("div_two_busy", 8'h80, v);
        chk("clk_low_step_two", 8'h00, {5'h00, clk_out});
        host.wr(DRS_OFS_DIV_FIRE, 8'h80);
        for (k = 1; k <= 12; k++) begin
            @(posedge clk_i);
            #1;
            if (clk_out !== 3'b000) break;
        end
        chk("clk_restart_together", 8'h07, {5'h00, clk_out});
        chk("clk_restart_in_time", 8'h01, {7'h00, k <= DRS_RESTART_MAX_CYC});
        host.rd(DRS_OFS_DIV_STEP_ONE, v);
        chk("div_one_clear", 8'h2f, v);
        host.rd(DRS_OFS_DIV_STEP_TWO, v);
        chk("div_two_clear", 8'h00, v);
        host.rd(DRS_OFS_DIV_FIRE, v);
        chk("div_fire_clear", 8'h00, v);
    endtask

    // Reference burst: count rising pulses and check every cycle's shape
    task automatic ref_run(input logic [7:0] n);
        int rises;
        logic [3:0] prev;
        rises = 0;
        prev = 4'h0;
        // Count is a level input, so change it on a clock edge
        @(posedge clk_i);
        pulse_cnt <= n;
        host.wr(DRS_OFS_REF_STEP_ONE, 8'h80);
        host.rd(DRS_OFS_REF_STEP_ONE, v);
        chk("ref_one_busy", 8'h80, v);
        host.wr(DRS_OFS_REF_STEP_TWO, 8'h80);
        host.rd(DRS_OFS_REF_STEP_TWO, v);
        chk("ref_two_busy", 8'h80, v);
        chk("ref_low_step_two", 8'h00, {4'h0, ref_out});
        host.wr(DRS_OFS_REF_FIRE, 8'h80);
        repeat (8 * n + 20) begin
            @(posedge clk_i);
            #1;
            chk("ref_shape", {4'h0, (ref_out !== 4'h0) ? ref_en : 4'h0}, {4'h0, ref_out});
            if (prev == 4'h0 && ref_out != 4'h0) rises++;
            prev = ref_out;
        end
        chk("ref_pulse_count", n, 8'(rises));
        host.rd(DRS_OFS_REF_FIRE, v);
        chk("ref_fire_clear", 8'h00, v);
        host.rd(DRS_OFS_REF_STEP_TWO, v);
        chk("ref_two_clear", 8'h00, v);
        host.rd(DRS_OFS_REF_STEP_ONE, v);
        chk("ref_one_clear", 8'h00, v);
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        final_report;
    end

    initial begin
        logic [7:0] offs [6];
        logic [7:0] counts [3];
        offs = '{8'h05, 8'h07, 8'h19, 8'h1b, 8'h1d, 8'h1f};
        counts = '{8'h01, 8'h00, 8'h05};
        num_errors = 0;
        n_checks = 0;
        clk_i = 1'b0;
        rst_i = 1'b1;
        ratio = '{7'h02, 7'h03, 7'h05};
        pulse_cnt = 8'h00;
        override_mode = 1'b0;
        ref_en = 4'hb;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (offs[i]) begin
            host.rd(offs[i], v);
            chk("reset_value", 8'h00, v);
        end
        host.rd(8'h0a, v);
        chk("unmapped_read", 8'h00, v);
        // Out-of-order and zero writes must leave everything idle
        host.wr(DRS_OFS_DIV_FIRE, 8'h80);
        host.rd(DRS_OFS_DIV_FIRE, v);
        chk("div_fire_alone", 8'h00, v);
        host.wr(DRS_OFS_DIV_STEP_ONE, 8'h7f);
        host.rd(DRS_OFS_DIV_STEP_ONE, v);
        chk("div_zero_write", 8'h2f, v);
        div_run;
        // New ratios land on a clock edge, then the sequence is rerun
        @(posedge clk_i);
        ratio <= '{7'h04, 7'h07, 7'h01};
        div_run;
        // Host shortcut run keeps the three-step order
        host.run_seq(DRS_OFS_DIV_STEP_ONE, DRS_OFS_DIV_STEP_TWO, DRS_OFS_DIV_FIRE);
        repeat (12) @(posedge clk_i);
        host.rd(DRS_OFS_DIV_FIRE, v);
        chk("div_seq_done", 8'h00, v);
        // Override blocks reference step one; with override off, a lone step two and fire are dropped
        @(posedge clk_i);
        override_mode <= 1'b1;
        host.wr(DRS_OFS_REF_STEP_ONE, 8'h80);
        host.rd(DRS_OFS_REF_STEP_ONE, v);
        chk("ref_override", 8'h00, v);
        @(posedge clk_i);
        override_mode <= 1'b0;
        host.wr(DRS_OFS_REF_STEP_TWO, 8'h80);
        host.rd(DRS_OFS_REF_STEP_TWO, v);
        chk("ref_two_alone", 8'h00, v);
        host.wr(DRS_OFS_REF_FIRE, 8'h80);
        repeat (30) @(posedge clk_i);
        #1;
        chk("ref_fire_alone", 8'h00, {4'h0, ref_out});
        foreach (counts[i]) begin
            ref_run(counts[i]);
        end
        final_report;
    end
endmodule
`default_nettype wire
